//--- core/lbt_defines.svh
// Constants for the backlight idle timer
//////////////////////////////////////////////////////////////////////////////
// How it works
// - Idle timeout setting 0 to 15 minutes, one-minute steps, sets backlight off time.
// - Timeout of zero disables saving; backlight stays lit.
// - When idle minutes equal timeout, only backlight turns off.
// - Only real print data commands count as activity, not status, cancel, bad data.
// - Idle counts only while no button is held.
// - Idle counts only while not in error state.
// - Idle counts only while not printing or feeding media.
// - Saving works in online, offline, hex dump; inactive in download mode.
// - Backlight relights on print data, button press, error, or print start.
// - Button press while backlight off only relights; its action is suppressed.
//////////////////////////////////////////////////////////////////////////////
`ifndef LBT_DEFINES_SVH
`define LBT_DEFINES_SVH
`define LBT_CLK_HZ 64'h0000_0000_05F5_E100
`define LBT_MINUTE_S 64'h0000_0000_0000_003C
// Kept at 64 bits: a minute of system clock does not fit in 32
`define LBT_MINUTE_CYC (`LBT_CLK_HZ * `LBT_MINUTE_S)
`define LBT_TIMEOUT_MAX 4'hF
`define LBT_TIMEOUT_OFF 4'h0
`define LBT_TIMEOUT_W 32'h4
`define LBT_BTN_W 32'h6
`endif

//--- core/lbt_pkg.sv
// Types for the backlight idle timer
package lbt_pkg;
   typedef enum logic [1:0] {LBT_ONLINE, LBT_OFFLINE, LBT_HEXDUMP, LBT_DOWNLOAD} lbt_mode_e;
   typedef enum {LBT_LIT, LBT_DARK} lbt_state_e;
   // Product status sampled each cycle
   typedef struct packed {
      logic print_cmd;
      logic status_req;
      logic cancel_req;
      logic bad_data;
      logic error;
      logic printing;
      logic feeding;
      logic print_start;
      lbt_mode_e mode;
   } lbt_status_s;
endpackage

//--- core/lbt_minute_tick.sv
// Minute tick generator from the system clock
`include "lbt_defines.svh"
module lbt_minute_tick #(
   parameter longint unsigned TICK_CYC = `LBT_MINUTE_CYC
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Control
   input wire logic clr,
   output logic tick
);
   // Counter sized from the period, since a real minute needs more than 32 bits
   localparam int CW = $clog2(TICK_CYC);
   localparam logic [CW-1:0] LAST = CW'(TICK_CYC - 64'h1);
   if (TICK_CYC < 2 || TICK_CYC > 64'h0000_0100_0000_0000) begin : g_bad_tick
      $error("TICK_CYC out of range");
   end
   typedef struct packed {
      logic [CW-1:0] cnt;
      logic tick;
   } lbt_tick_s;
   lbt_tick_s st_q, st_d;
   always_comb begin
      st_d = st_q;
      st_d.tick = 1'b0;
      if (clr) begin
         st_d.cnt = '0;
      end else if (st_q.cnt == LAST) begin
         st_d.cnt = '0;
         st_d.tick = 1'b1;
      end else begin
         st_d.cnt = st_q.cnt + CW'(1);
      end
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign tick = st_q.tick;
endmodule

//--- core/lbt_idle_timer.sv
// Backlight idle timer: counts idle minutes and switches backlight
`include "lbt_defines.svh"
module lbt_idle_timer
   import lbt_pkg::*;
#(
   parameter longint unsigned MINUTE_CYC = `LBT_MINUTE_CYC,
   parameter int BTN_W = `LBT_BTN_W
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Configuration
   input wire logic [`LBT_TIMEOUT_W-1:0] backlight_idle_timeout,
   // Product status
   input wire lbt_pkg::lbt_status_s status,
   // Operator buttons
   input wire logic [BTN_W-1:0] btn_raw,
   output logic [BTN_W-1:0] btn_out,
   // Display
   output logic backlight_on,
   output logic [`LBT_TIMEOUT_W-1:0] idle_minutes
);
   import lbt_pkg::*;
   // Refuse sizes the counters and masks cannot serve
   if (BTN_W < 1) begin : g_bad_btn_w
      $error("BTN_W must be at least 1");
   end
   if (MINUTE_CYC < 2) begin : g_bad_minute
      $error("MINUTE_CYC must be at least 2");
   end
   //////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      lbt_state_e st;
      logic [`LBT_TIMEOUT_W-1:0] idle;
      logic [BTN_W-1:0] btn_prev;
      logic [BTN_W-1:0] swallow;
      logic [BTN_W-1:0] btn_out;
      logic lit;
   } lbt_top_s;
   lbt_top_s s_q, s_d;
   logic tick;
   logic print_data;
   logic btn_any;
   logic btn_new;
   logic busy;
   logic mode_ok;
   logic enabled;
   logic quiet;
   // Only real print commands count as data
   assign print_data = status.print_cmd && !status.status_req && !status.cancel_req
                       && !status.bad_data;
   assign btn_any = |btn_raw;
   assign btn_new = |(btn_raw & ~s_q.btn_prev);
   assign busy = status.error || status.printing || status.feeding;
   assign mode_ok = (status.mode != LBT_DOWNLOAD);
   assign enabled = (backlight_idle_timeout != `LBT_TIMEOUT_OFF) && mode_ok;
   // A print start is activity too, so a relight lasts at least a full minute
   assign quiet = enabled && !print_data && !btn_any && !busy
                  && !status.print_start;
   // Tick phase restarts with any activity so a minute is a full minute
   lbt_minute_tick #(.TICK_CYC(MINUTE_CYC)) u_tick (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .clr(!quiet),
      .tick(tick)
   );
   //////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_d = s_q;
      s_d.btn_prev = btn_raw;
      if (!quiet) begin
         s_d.idle = '0;
      end else if (tick && s_q.idle != `LBT_TIMEOUT_MAX) begin
         s_d.idle = s_q.idle + 1'b1;
      end
      case (s_q.st)
         LBT_LIT: begin
            s_d.swallow = s_q.swallow & btn_raw;
            // Content is untouched; only the backlight drive drops
            if (quiet && s_q.idle == backlight_idle_timeout) begin
               s_d.st = LBT_DARK;
               s_d.lit = 1'b0;
            end
         end
         LBT_DARK: begin
            if (!enabled || print_data || btn_new || status.error
                || status.print_start || busy) begin
               s_d.st = LBT_LIT;
               s_d.lit = 1'b1;
               s_d.idle = '0;
            end
            // Held buttons stay masked until released
            s_d.swallow = btn_raw;
         end
         default: begin
            s_d.st = LBT_LIT;
            s_d.lit = 1'b1;
         end
      endcase
      s_d.btn_out = btn_raw & ~s_d.swallow;
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '{st: LBT_LIT, idle: '0, btn_prev: '0, swallow: '0, btn_out: '0, lit: 1'b1};
      end else begin
         s_q <= s_d;
      end
   end
   assign backlight_on = s_q.lit;
   assign btn_out = s_q.btn_out;
   assign idle_minutes = s_q.idle;
   //////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   a_zero_stays_lit: assert property (
      backlight_idle_timeout == `LBT_TIMEOUT_OFF |=> backlight_on)
      else $error("backlight off with zero timeout");
   a_download_lit: assert property (
      status.mode == LBT_DOWNLOAD |=> backlight_on)
      else $error("backlight off in download mode");
   a_off_at_timeout: assert property (
      backlight_on && quiet && idle_minutes == backlight_idle_timeout |=> !backlight_on)
      else $error("backlight not switched off at timeout");
   a_no_early_off: assert property (
      $fell(backlight_on) |-> $past(idle_minutes) == $past(backlight_idle_timeout))
      else $error("backlight off before timeout");
   a_btn_clears: assert property (
      btn_any |=> idle_minutes == '0)
      else $error("idle count not cleared by button");
   a_busy_clears: assert property (
      busy |=> idle_minutes == '0)
      else $error("idle count not cleared while busy");
   a_data_clears: assert property (
      print_data |=> idle_minutes == '0)
      else $error("idle count not cleared by print data");
   a_wake_on_data: assert property (
      !backlight_on && print_data |=> backlight_on)
      else $error("no wake on print data");
   a_swallow_btn: assert property (
      !backlight_on && btn_new |=> btn_out == '0)
      else $error("button passed while backlight off");
   a_idle_step: assert property (
      idle_minutes != $past(idle_minutes) && idle_minutes != '0
      |-> idle_minutes == $past(idle_minutes) + 1'b1)
      else $error("idle count jumped");
   c_goes_dark: cover property ($fell(backlight_on));
   c_wakes_btn: cover property (!backlight_on && btn_new ##1 backlight_on);
   c_wakes_data: cover property (!backlight_on && print_data ##1 backlight_on);
   c_wakes_start: cover property (!backlight_on && status.print_start ##1 backlight_on);
   c_mask_ends: cover property (s_q.swallow != '0 ##1 s_q.swallow == '0);
   //////////////////////////////////////////////////////////////////////////
   // Idle minute counting
   a_quiet_holds: assert property (
      quiet && !tick
      |=> $stable(idle_minutes))
      else $error("idle count moved without a minute tick");

   a_tick_counts: assert property (
      quiet && tick && idle_minutes != `LBT_TIMEOUT_MAX
      |=> idle_minutes == $past(idle_minutes) + 4'h1)
      else $error("idle count missed a minute tick");

   a_idle_saturates: assert property (
      quiet && tick && idle_minutes == `LBT_TIMEOUT_MAX
      |=> idle_minutes == `LBT_TIMEOUT_MAX)
      else $error("idle count wrapped past its top");

   a_loud_clears: assert property (
      !quiet
      |=> idle_minutes == '0)
      else $error("idle count kept through activity");

   a_tick_spacing: assert property (
      tick
      |=> !tick)
      else $error("minute ticks back to back");

   a_tick_held_off: assert property (
      !quiet
      |=> !tick)
      else $error("minute tick right after activity");

   a_wake_zeroes: assert property (
      $rose(backlight_on)
      |-> idle_minutes == '0)
      else $error("idle count not zero after wake");

   //////////////////////////////////////////////////////////////////////////
   // Timeout and backlight state
   a_lit_until_due: assert property (
      backlight_on && idle_minutes != backlight_idle_timeout
      |=> backlight_on)
      else $error("backlight off before the set minutes");

   a_zero_no_count: assert property (
      backlight_idle_timeout == `LBT_TIMEOUT_OFF
      |=> idle_minutes == '0)
      else $error("idle count runs with saving disabled");

   a_zero_wakes: assert property (
      !backlight_on && backlight_idle_timeout == `LBT_TIMEOUT_OFF
      |=> backlight_on)
      else $error("dark backlight kept after saving disabled");

   a_fall_enabled: assert property (
      $fell(backlight_on)
      |-> $past(backlight_idle_timeout) != `LBT_TIMEOUT_OFF)
      else $error("backlight off with saving disabled");

   a_lit_state: assert property (
      backlight_on
      |-> s_q.st == LBT_LIT)
      else $error("backlight lit outside the lit state");

   a_dark_state: assert property (
      !backlight_on
      |-> s_q.st == LBT_DARK)
      else $error("backlight dark outside the dark state");

   a_dark_stays: assert property (
      !backlight_on && quiet
      |=> !backlight_on)
      else $error("backlight relit with no wake event");

   a_fall_quiet: assert property (
      $fell(backlight_on)
      |-> $past(quiet))
      else $error("backlight off after an active cycle");

   //////////////////////////////////////////////////////////////////////////
   // Idle conditions: what counts as print data, and what holds when the backlight goes out
   a_fall_no_data: assert property (
      $fell(backlight_on)
      |-> !$past(print_data))
      else $error("backlight off while print data arrived");

   a_status_not_data: assert property (
      status.status_req
      |-> !print_data)
      else $error("status request taken as print data");

   a_cancel_not_data: assert property (
      status.cancel_req
      |-> !print_data)
      else $error("cancel request taken as print data");

   a_bad_not_data: assert property (
      status.bad_data
      |-> !print_data)
      else $error("malformed data taken as print data");

   a_filtered_no_wake: assert property (
      !backlight_on && quiet && status.print_cmd
      |=> !backlight_on)
      else $error("filtered data relit the backlight");

   a_fall_no_btn: assert property (
      $fell(backlight_on)
      |-> $past(btn_raw) == '0)
      else $error("backlight off while a button was held");

   a_fall_no_error: assert property (
      $fell(backlight_on)
      |-> !$past(status.error))
      else $error("backlight off in the error state");

   a_fall_not_moving: assert property (
      $fell(backlight_on)
      |-> !$past(status.printing) && !$past(status.feeding))
      else $error("backlight off while media moved");

   a_fall_mode_ok: assert property (
      $fell(backlight_on)
      |-> $past(status.mode) != LBT_DOWNLOAD)
      else $error("backlight off in download mode");

   a_download_zero: assert property (
      status.mode == LBT_DOWNLOAD
      |=> idle_minutes == '0)
      else $error("idle count runs in download mode");

   //////////////////////////////////////////////////////////////////////////
   // Wake events
   a_wake_on_btn: assert property (
      !backlight_on && btn_new
      |=> backlight_on)
      else $error("no wake on button press");

   a_wake_on_error: assert property (
      !backlight_on && status.error
      |=> backlight_on)
      else $error("no wake on error");

   a_wake_on_start: assert property (
      !backlight_on && status.print_start
      |=> backlight_on)
      else $error("no wake on print start");

   a_wake_on_move: assert property (
      !backlight_on && (status.printing || status.feeding)
      |=> backlight_on)
      else $error("no wake while media moves");

   //////////////////////////////////////////////////////////////////////////
   // Button pass-through and suppression
   a_dark_no_btn: assert property (
      !backlight_on
      |-> btn_out == '0)
      else $error("button passed on while dark");

   a_out_only_held: assert property (
      rst_b
      |=> (btn_out & ~$past(btn_raw)) == '0)
      else $error("button passed on that was not held");

   a_lit_passes: assert property (
      backlight_on && s_q.swallow == '0
      |=> btn_out == $past(btn_raw))
      else $error("button lost while lit");

   a_held_masked: assert property (
      backlight_on && (btn_raw & s_q.swallow) != '0
      |=> (btn_out & $past(btn_raw & s_q.swallow)) == '0)
      else $error("waking button passed on before release");
endmodule

//--- verif/lbt_panel_model.sv
// Operator panel and product status sources seen by the idle timer
module lbt_panel_model
   import lbt_pkg::*;
#(
   parameter int BTN_W = 6
) (
   // Clock
   input wire logic clk_sys,
   // Toward the block
   output lbt_pkg::lbt_status_s status,
   output logic [BTN_W-1:0] btn_raw
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      status = '0;
      btn_raw = '0;
   end
   // Levels move just after an edge so the block never samples a changing value
   task automatic drive(input lbt_status_s st, input logic [BTN_W-1:0] b);
      @(posedge clk_sys);
      #1;
      status = st;
      btn_raw = b;
   endtask
endmodule

//--- verif/tb_lbt_idle_timer.sv
// Self-checking bench for the backlight idle timer
module tb_lbt_idle_timer;
   timeunit 1ns;
   timeprecision 100ps;
   import lbt_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] tmo = 4'h0;
   lbt_status_s st;
   logic [5:0] btn;
   logic [5:0] btn_out;
   logic bl;
   logic [3:0] idle;
   int err_count = 0;
   int checks_done = 0;
   int cyc = 0;
   int wk[5] = '{0, 4, 5, 6, 7};
   always #5 clk_sys = ~clk_sys;
   lbt_idle_timer #(.MINUTE_CYC(20), .BTN_W(6)) i_dut (.clk_sys(clk_sys), .rst_b(rst_b),
      .backlight_idle_timeout(tmo), .status(st), .btn_raw(btn), .btn_out(btn_out),
      .backlight_on(bl), .idle_minutes(idle));
   lbt_panel_model #(.BTN_W(6)) i_panel (.clk_sys(clk_sys), .status(st), .btn_raw(btn));
   //////////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      if (err_count == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // Bounded wait: a block that never darkens fails the following compare
   task automatic go_dark;
      int n;
      n = 0;
      while (bl !== 1'b0 && n < 200) begin
         wait_cyc(1);
         n++;
      end
   endtask
   // Hang guard well above the several hundred cycles the sequence needs
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 8000) begin
         err_count++;
         close_out();
      end
   end
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge clk_sys);
      #1 rst_b = 1'b1;
      wait_cyc(1);
      cmp(bl, 1);
      cmp(idle, 0);
      cmp(btn_out, 0);
      wait_cyc(100);
      cmp(bl, 1);
      tmo = 4'h3;
      go_dark();
      cmp(bl, 0);
      cmp(idle, 3);
      i_panel.drive('0, 6'h04);
      wait_cyc(2);
      cmp(bl, 1);
      cmp(idle, 0);
      wait_cyc(3);
      cmp(btn_out, 0);
      i_panel.drive('0, 6'h00);
      tmo = 4'h1;
      i_panel.drive('0, 6'h04);
      wait_cyc(50);
      cmp(bl, 1);
      cmp(btn_out, 8'h04);
      i_panel.drive('0, 6'h00);
      foreach (wk[i]) begin
         go_dark();
         cmp(bl, 0);
         i_panel.drive(lbt_status_s'(10'h200 >> wk[i]), 6'h00);
         wait_cyc(2);
         cmp(bl, 1);
         // A held source keeps it lit; a held print start counts as activity as well
         wait_cyc(50);
         cmp(bl, 1);
         i_panel.drive('0, 6'h00);
      end
      go_dark();
      for (int k = 1; k < 4; k++) begin
         i_panel.drive(lbt_status_s'(10'h200 | (10'h200 >> k)), 6'h00);
         wait_cyc(2);
         cmp(bl, 0);
      end
      // Offline and hex dump modes each start from a lit display, woken by a short press
      for (int m = 1; m < 3; m++) begin
         i_panel.drive(lbt_status_s'(10'(m)), 6'h01);
         i_panel.drive(lbt_status_s'(10'(m)), 6'h00);
         wait_cyc(2);
         cmp(bl, 1);
         go_dark();
         cmp(bl, 0);
      end
      i_panel.drive(lbt_status_s'(10'(LBT_DOWNLOAD)), 6'h00);
      wait_cyc(60);
      cmp(bl, 1);
      cmp(idle, 0);
      close_out();
   end
endmodule
